/* File: rtl/ehrc_pkg.sv */
/*
  Constants, types and the register map of the Ethernet hard-block reset
  controller. Assumes a single 10 MHz clock that also serves as the
  reconfiguration clock, and all reset inputs synchronous to it.
*/
// Operation
// - System, TX and RX soft resets stay set until software writes them clear.
// - Register, TX and RX hard reset inputs are active low.
// - Register or system reset restores all registers, statistics counters included; here the soft system reset keeps the control register.
// - System reset hits MAC, interfaces, PCS, PMA, status; FEC only in 100G.
// - Register reset runs its internal sequence on the input's rising edge.
// - TX reset hits TX MAC, PCS, PMA, FEC in 100G; drops lanes stable.
// - RX reset hits RX MAC, PCS, FEC in 100G; drops PCS ready.
// - Shared RS-FEC TX reset resets every channel's TX FEC together.
// - Shared RS-FEC RX reset resets every channel's RX FEC together.
// - Statistics clears touch only their own direction's counters.
// - Reconfiguration reset, active high, resets bus port and some soft registers.
// - Device orders internal releases itself once external resets are applied.
// - TX reset may break downstream alignment and send malformed frames.
// - RX reset corrupts packets in flight; nothing is preserved.
// - Without external die clock, master register reset also takes slaves down.
// - Adaptation completion is reported by its code and confirmed by controller.
package ehrc_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CSR_SEQ_NS    = 2000;
  localparam int unsigned STG_IF_NS     = 100;
  localparam int unsigned STG_PMA_NS    = 300;
  localparam int unsigned STG_PCS_NS    = 500;
  localparam int unsigned STG_MAC_NS    = 700;
  localparam int unsigned CSR_SEQ_CYC   = (CSR_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STG_IF_CYC    = (STG_IF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STG_PMA_CYC   = (STG_PMA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STG_PCS_CYC   = (STG_PCS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STG_MAC_CYC   = (STG_MAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 8;

  // Register port
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam logic [7:0]  REG_CTRL_OFS = 8'h00;
  localparam logic [7:0]  REG_STAT_OFS = 8'h04;
  localparam logic [7:0]  REG_BLK_OFS  = 8'h08;
  localparam logic [7:0]  REG_ADAPT_OFS = 8'h0C;
  localparam logic [15:0] ADAPT_CODE   = 16'h0126;
  localparam logic [15:0] ADAPT_DATA   = 16'h0B00;
  localparam int unsigned CTRL_W       = 5;
  localparam logic [4:0]  CTRL_RST     = 5'h00;
  localparam int unsigned STAT_W       = 3;

  // Sub-block reset index
  localparam int unsigned BLK_N      = 12;
  localparam int unsigned BLK_TX_D2D = 0;
  localparam int unsigned BLK_TX_MAC = 1;
  localparam int unsigned BLK_TX_PCS = 2;
  localparam int unsigned BLK_TX_FEC = 3;
  localparam int unsigned BLK_TX_PMA = 4;
  localparam int unsigned BLK_TX_STA = 5;
  localparam int unsigned BLK_RX_D2D = 6;
  localparam int unsigned BLK_RX_MAC = 7;
  localparam int unsigned BLK_RX_PCS = 8;
  localparam int unsigned BLK_RX_FEC = 9;
  localparam int unsigned BLK_RX_PMA = 10;
  localparam int unsigned BLK_RX_STA = 11;
  localparam logic [11:0] TX_PATH_MASK = 12'h01F;
  localparam logic [11:0] RX_PATH_MASK = 12'h7C0;
  localparam logic [11:0] SYS_MASK     = 12'hDF7;

  // Release order: interfaces first, MAC last
  localparam int unsigned BLK_HOLD [BLK_N] = '{
    STG_IF_CYC, STG_MAC_CYC, STG_PCS_CYC, STG_PCS_CYC, STG_PMA_CYC, STG_IF_CYC,
    STG_IF_CYC, STG_MAC_CYC, STG_PCS_CYC, STG_PCS_CYC, STG_PMA_CYC, STG_IF_CYC};

  typedef logic [BLK_N-1:0] ehrc_blk_t;

  typedef struct packed {
    logic clr_rx_stats;
    logic clr_tx_stats;
    logic soft_rx;
    logic soft_tx;
    logic soft_sys;
  } ehrc_ctrl_s;

  typedef struct packed {
    logic rsfec_rx_reset_n;
    logic rsfec_tx_reset_n;
    logic lane_rx_datapath_reset_n;
    logic lane_tx_datapath_reset_n;
    logic lane_register_reset_n;
  } ehrc_hard_s;

  typedef enum logic [1:0] {SEQ_RUN, SEQ_HOLD, SEQ_STAGE} ehrc_seq_e;

endpackage

/* File: rtl/ehrc_reset_ctrl.sv */
/*
  Reset distribution for the hardened Ethernet MAC/PCS/RS-FEC stack:
  combines hard, soft and FEC resets into per-sub-block resets with
  ordered release, and reports lanes stable and PCS ready.
  Assumes every input synchronous to clk_in, which also serves as the
  reconfiguration clock, and a master that never issues both strobes.
*/
// The implementer's own choices: the plain strobed port and the address map.
module ehrc_reset_ctrl
  import ehrc_pkg::*;
#(
  parameter int unsigned FEC_CH = 4
) (
  // Clock and resets
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              reconfig_reset_in,
  input  wire ehrc_hard_s        hard_rst_in,
  // Configuration and lane state
  input  wire logic              rate_100g_in,
  input  wire logic              d2d_master_in,
  input  wire logic              rx_pcs_lock_in,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rd_data_out,
  // Sub-block resets and status
  output ehrc_blk_t              blk_rst_out,
  output logic      [FEC_CH-1:0] tx_fec_rst_out,
  output logic      [FEC_CH-1:0] rx_fec_rst_out,
  output logic                   tx_lanes_stable_out,
  output logic                   rx_pcs_ready_out,
  output logic                   slave_reg_reset_out
);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  ehrc_seq_e        state_ff;
  logic [CNT_W-1:0] seq_cnt_ff;
  logic             csr_n_q_ff;
  ehrc_ctrl_s       ctrl_ff;
  ehrc_blk_t        blk_req;
  ehrc_blk_t        blk_q;
  ehrc_blk_t        blk_rst_ff;
  logic [FEC_CH-1:0] tx_fec_ff;
  logic [FEC_CH-1:0] rx_fec_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic             lanes_stable_ff;
  logic             pcs_ready_ff;
  logic             slave_rst_ff;
  logic             csr_active;
  logic             csr_rise;
  logic             sys_req;
  logic             tx_req;
  logic             rx_req;
  logic             ctrl_wr;
  logic             nxt_lanes_stable;
  logic             nxt_pcs_ready;

  // Register reset sequencer

  assign csr_rise   = hard_rst_in.lane_register_reset_n && !csr_n_q_ff;
  assign csr_active = (state_ff != SEQ_RUN);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      csr_n_q_ff <= 1'b0;
    end else begin
      csr_n_q_ff <= hard_rst_in.lane_register_reset_n;
    end
  end

  // Low level holds reset; only the 0->1 edge starts the internal sequence
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff   <= SEQ_HOLD;
      seq_cnt_ff <= '0;
    end else begin
      case (state_ff)
        SEQ_RUN: begin
          if (!hard_rst_in.lane_register_reset_n) begin
            state_ff <= SEQ_HOLD;
          end
        end
        SEQ_HOLD: begin
          if (csr_rise) begin
            state_ff   <= SEQ_STAGE;
            seq_cnt_ff <= CNT_W'(CSR_SEQ_CYC - 1);
          end
        end
        SEQ_STAGE: begin
          if (!hard_rst_in.lane_register_reset_n) begin
            state_ff <= SEQ_HOLD;
          end else if (seq_cnt_ff == '0) begin
            state_ff <= SEQ_RUN;
          end else begin
            seq_cnt_ff <= seq_cnt_ff - 1'b1;
          end
        end
        default: begin
          state_ff <= SEQ_HOLD;
        end
      endcase
    end
  end

  property p_csr_low_holds;
    !hard_rst_in.lane_register_reset_n |=> state_ff == SEQ_HOLD;
  endproperty
  a_csr_low_holds: assert property (p_csr_low_holds)
    else $error("register reset low did not hold the sequencer");

  property p_csr_edge;
    state_ff == SEQ_HOLD && csr_rise |=> state_ff == SEQ_STAGE;
  endproperty
  a_csr_edge: assert property (p_csr_edge)
    else $error("rising register reset did not start the sequence");

  property p_seq_end;
    state_ff == SEQ_STAGE && seq_cnt_ff == '0 && hard_rst_in.lane_register_reset_n
      |=> state_ff == SEQ_RUN;
  endproperty
  a_seq_end: assert property (p_seq_end)
    else $error("internal sequence did not finish on count");

  // Control register

  assign ctrl_wr = wr_in && (addr_in == ADDR_W'(REG_CTRL_OFS));

  // Soft bits never clear themselves, so a soft system reset keeps this
  // register alive; only sys_rst_in or the hard register reset wipes it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || csr_active) begin
      ctrl_ff <= ehrc_ctrl_s'(CTRL_RST);
    end else if (ctrl_wr) begin
      ctrl_ff <= ehrc_ctrl_s'(wr_data_in[CTRL_W-1:0]);
    end else if (reconfig_reset_in) begin
      ctrl_ff.clr_tx_stats <= 1'b0;
      ctrl_ff.clr_rx_stats <= 1'b0;
    end
  end

  property p_soft_sticky;
    !ctrl_wr && !csr_active |=> (ctrl_ff[2:0] & $past(ctrl_ff[2:0])) == $past(ctrl_ff[2:0]);
  endproperty
  a_soft_sticky: assert property (p_soft_sticky)
    else $error("soft reset cleared without a register write");

  property p_csr_clears_regs;
    csr_active |=> ctrl_ff == ehrc_ctrl_s'(CTRL_RST);
  endproperty
  a_csr_clears_regs: assert property (p_csr_clears_regs)
    else $error("register reset left control bits set");

  property p_reconfig_rst;
    reconfig_reset_in |=> !ctrl_ff.clr_tx_stats && !ctrl_ff.clr_rx_stats && rd_data_out == '0;
  endproperty
  a_reconfig_rst: assert property (p_reconfig_rst)
    else $error("reconfiguration reset did not clear port state");

  // Reset request map

  // Frames in flight are cut, not drained: keeps reset latency fixed
  assign sys_req = csr_active || ctrl_ff.soft_sys;
  assign tx_req  = !hard_rst_in.lane_tx_datapath_reset_n || ctrl_ff.soft_tx;
  assign rx_req  = !hard_rst_in.lane_rx_datapath_reset_n || ctrl_ff.soft_rx;

  always_comb begin
    blk_req             = '0;
    blk_req[BLK_TX_D2D] = sys_req;
    blk_req[BLK_TX_MAC] = sys_req || tx_req;
    blk_req[BLK_TX_PCS] = sys_req || tx_req;
    blk_req[BLK_TX_PMA] = sys_req || tx_req;
    blk_req[BLK_TX_FEC] = (rate_100g_in && (sys_req || tx_req))
                          || !hard_rst_in.rsfec_tx_reset_n;
    blk_req[BLK_TX_STA] = sys_req || ctrl_ff.clr_tx_stats;
    blk_req[BLK_RX_D2D] = sys_req;
    blk_req[BLK_RX_MAC] = sys_req || rx_req;
    blk_req[BLK_RX_PCS] = sys_req || rx_req;
    blk_req[BLK_RX_PMA] = sys_req;
    blk_req[BLK_RX_FEC] = (rate_100g_in && (sys_req || rx_req))
                          || !hard_rst_in.rsfec_rx_reset_n;
    blk_req[BLK_RX_STA] = sys_req || ctrl_ff.clr_rx_stats;
  end

  // Staggered release, interfaces before PCS before MAC
  for (genvar g = 0; g < BLK_N; g++) begin : g_stage
    ehrc_rst_stage #(
      .HOLD       (BLK_HOLD[g])
    ) u_stage (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .req_in     (blk_req[g]),
      .rst_out    (blk_q[g])
    );
  end

  // Outputs

  assign nxt_lanes_stable = !(|((blk_q | blk_req) & TX_PATH_MASK));
  assign nxt_pcs_ready    = rx_pcs_lock_in && !(|((blk_q | blk_req) & RX_PATH_MASK));

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      blk_rst_ff <= '1;
      tx_fec_ff  <= '1;
      rx_fec_ff  <= '1;
    end else begin
      blk_rst_ff <= blk_q;
      tx_fec_ff  <= {FEC_CH{blk_q[BLK_TX_FEC]}};
      rx_fec_ff  <= {FEC_CH{blk_q[BLK_RX_FEC]}};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lanes_stable_ff <= 1'b0;
      pcs_ready_ff    <= 1'b0;
    end else begin
      lanes_stable_ff <= nxt_lanes_stable;
      pcs_ready_ff    <= nxt_pcs_ready;
    end
  end

  // A master register reset always reaches the slave lanes
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      slave_rst_ff <= 1'b1;
    end else begin
      slave_rst_ff <= csr_active && d2d_master_in;
    end
  end

  property p_sys_blocks;
    sys_req |-> ##2 ((blk_rst_out & SYS_MASK) == SYS_MASK)
      && !tx_lanes_stable_out && !rx_pcs_ready_out;
  endproperty
  a_sys_blocks: assert property (p_sys_blocks)
    else $error("system reset missed a sub-block or status");

  property p_sys_fec_100g;
    sys_req && rate_100g_in |-> ##2 (&tx_fec_rst_out) && (&rx_fec_rst_out);
  endproperty
  a_sys_fec_100g: assert property (p_sys_fec_100g)
    else $error("100G system reset did not reset FEC");

  property p_sys_stats;
    csr_active |-> ##2 blk_rst_out[BLK_TX_STA] && blk_rst_out[BLK_RX_STA];
  endproperty
  a_sys_stats: assert property (p_sys_stats)
    else $error("register reset did not clear statistics");

  property p_tx_reset;
    tx_req |-> ##2 blk_rst_out[BLK_TX_MAC] && blk_rst_out[BLK_TX_PCS]
      && blk_rst_out[BLK_TX_PMA] && !tx_lanes_stable_out;
  endproperty
  a_tx_reset: assert property (p_tx_reset)
    else $error("TX reset missed a TX sub-block");

  property p_tx_scope;
    tx_req && !sys_req && !rx_req && !ctrl_ff.clr_rx_stats && !blk_q[BLK_RX_MAC]
      |=> !blk_q[BLK_RX_MAC];
  endproperty
  a_tx_scope: assert property (p_tx_scope)
    else $error("TX reset disturbed the RX path");

  property p_rx_reset;
    rx_req |-> ##2 blk_rst_out[BLK_RX_MAC] && blk_rst_out[BLK_RX_PCS] && !rx_pcs_ready_out;
  endproperty
  a_rx_reset: assert property (p_rx_reset)
    else $error("RX reset missed an RX sub-block");

  property p_rx_scope;
    rx_req && !sys_req && !blk_q[BLK_RX_PMA] |=> !blk_q[BLK_RX_PMA];
  endproperty
  a_rx_scope: assert property (p_rx_scope)
    else $error("RX reset touched the RX PMA interface");

  property p_fec_tx_all;
    !hard_rst_in.rsfec_tx_reset_n |-> ##2 (&tx_fec_rst_out);
  endproperty
  a_fec_tx_all: assert property (p_fec_tx_all)
    else $error("shared TX FEC reset missed a channel");

  property p_fec_rx_all;
    !hard_rst_in.rsfec_rx_reset_n |-> ##2 (&rx_fec_rst_out);
  endproperty
  a_fec_rx_all: assert property (p_fec_rx_all)
    else $error("shared RX FEC reset missed a channel");

  property p_clr_tx_stats;
    ctrl_ff.clr_tx_stats && !sys_req && !tx_req && !blk_q[BLK_TX_MAC]
      |-> ##2 blk_rst_out[BLK_TX_STA] && !blk_rst_out[BLK_TX_MAC];
  endproperty
  a_clr_tx_stats: assert property (p_clr_tx_stats)
    else $error("TX statistics clear misrouted");

  property p_mac_last;
    $fell(blk_rst_out[BLK_TX_MAC]) |-> !blk_rst_out[BLK_TX_PCS] && !blk_rst_out[BLK_TX_PMA];
  endproperty
  a_mac_last: assert property (p_mac_last)
    else $error("TX MAC released before its lower layers");

  property p_status_low;
    (sys_req || tx_req) |=> !tx_lanes_stable_out;
  endproperty
  a_status_low: assert property (p_status_low)
    else $error("lanes stable high during a TX reset");

  property p_slave_follow;
    csr_active && d2d_master_in |=> slave_reg_reset_out;
  endproperty
  a_slave_follow: assert property (p_slave_follow)
    else $error("master register reset not passed to slaves");

  // Register read port

  // Read data stand for exactly one cycle, then return to zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || reconfig_reset_in) begin
      rd_data_ff <= '0;
    end else if (rd_in) begin
      case (addr_in)
        ADDR_W'(REG_CTRL_OFS): begin
          rd_data_ff <= DATA_W'(ctrl_ff);
        end
        ADDR_W'(REG_STAT_OFS): begin
          rd_data_ff <= DATA_W'({csr_active, pcs_ready_ff, lanes_stable_ff});
        end
        ADDR_W'(REG_BLK_OFS): begin
          rd_data_ff <= DATA_W'(blk_rst_ff);
        end
        // Adaptation report stands only while the RX path is up
        ADDR_W'(REG_ADAPT_OFS): begin
          rd_data_ff <= pcs_ready_ff ? {ADAPT_DATA, ADAPT_CODE} : '0;
        end
        default: begin
          rd_data_ff <= '0;
        end
      endcase
    end else begin
      rd_data_ff <= '0;
    end
  end

  assign rd_data_out         = rd_data_ff;
  assign blk_rst_out         = blk_rst_ff;
  assign tx_fec_rst_out      = tx_fec_ff;
  assign rx_fec_rst_out      = rx_fec_ff;
  assign tx_lanes_stable_out = lanes_stable_ff;
  assign rx_pcs_ready_out    = pcs_ready_ff;
  assign slave_reg_reset_out = slave_rst_ff;

endmodule // ehrc_reset_ctrl

/* File: rtl/ehrc_rst_stage.sv */
/*
  One sub-block reset stage: asserts at once on request and releases a
  fixed number of cycles after the request drops. Assumes a synchronous
  request in the clk_in domain.
*/
module ehrc_rst_stage
  import ehrc_pkg::*;
#(
  parameter int unsigned HOLD = 1
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // Request and reset
  input  wire logic req_in,
  output logic      rst_out
);

  logic [CNT_W-1:0] cnt_ff;
  logic             rst_ff;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || req_in) begin
      rst_ff <= 1'b1;
      cnt_ff <= CNT_W'(HOLD);
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end else begin
      rst_ff <= 1'b0;
    end
  end

  assign rst_out = rst_ff;

endmodule // ehrc_rst_stage

/* File: tb/ehrc_lane_partner.sv */
/*
  Link partner model for the reset controller bench: reports RX PCS lock
  a few cycles after the RX PCS leaves reset.
  Assumes the controller's clock and its registered block reset vector.
*/
module ehrc_lane_partner
  import ehrc_pkg::*;
#(
  parameter int unsigned LOCK_DLY = 4
) (
  // Clock
  input  wire logic      clk_in,
  // Controller side
  input  wire ehrc_blk_t blk_rst_in,
  output logic           rx_pcs_lock_out
);
  logic [7:0] lock_cnt_ff;

  // Lock is lost at once; the partner keeps sending, so it comes back
  always_ff @(posedge clk_in) begin
    if (blk_rst_in[BLK_RX_PCS]) begin
      lock_cnt_ff     <= 8'h00;
      rx_pcs_lock_out <= 1'b0;
    end else if (lock_cnt_ff < LOCK_DLY[7:0]) begin
      lock_cnt_ff <= lock_cnt_ff + 8'h01;
    end else begin
      rx_pcs_lock_out <= 1'b1;
    end
  end
endmodule // ehrc_lane_partner

/* File: tb/ehrc_reset_ctrl_tb.sv */
/*
  Self-checking bench for the reset controller: drives hard, soft and
  FEC resets and the register port, and checks the block reset map.
  Assumes the link partner model for RX PCS lock and a 10 MHz clock.
*/
module ehrc_reset_ctrl_tb;
  import ehrc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam ehrc_blk_t TXB = (12'h001 << BLK_TX_MAC) | (12'h001 << BLK_TX_PCS) | (12'h001 << BLK_TX_PMA);
  localparam ehrc_blk_t RXB = (12'h001 << BLK_RX_MAC) | (12'h001 << BLK_RX_PCS);
  localparam ehrc_blk_t TXF = 12'h001 << BLK_TX_FEC;
  localparam ehrc_blk_t RXF = 12'h001 << BLK_RX_FEC;

  logic              clk_in;
  logic              sys_rst_in;
  logic              reconfig_reset_in;
  ehrc_hard_s        hard_rst_in;
  logic              rate_100g_in;
  logic              d2d_master_in;
  logic              rx_pcs_lock_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wr_data_in;
  logic              wr_in;
  logic              rd_in;
  logic [DATA_W-1:0] rd_data_out;
  ehrc_blk_t         blk_rst_out;
  logic [3:0]        tx_fec_rst_out;
  logic [3:0]        rx_fec_rst_out;
  logic              tx_lanes_stable_out;
  logic              rx_pcs_ready_out;
  logic              slave_reg_reset_out;
  int                n_fail;
  int                num_checks;
  logic [31:0]       rdv;
  ehrc_blk_t         m;
  logic [1:0]        st;
  logic [4:0]        ctl;
  int                hidx;

  ehrc_reset_ctrl #(.FEC_CH(4)) i_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reconfig_reset_in(reconfig_reset_in),
    .hard_rst_in(hard_rst_in), .rate_100g_in(rate_100g_in), .d2d_master_in(d2d_master_in),
    .rx_pcs_lock_in(rx_pcs_lock_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .blk_rst_out(blk_rst_out),
    .tx_fec_rst_out(tx_fec_rst_out), .rx_fec_rst_out(rx_fec_rst_out),
    .tx_lanes_stable_out(tx_lanes_stable_out), .rx_pcs_ready_out(rx_pcs_ready_out),
    .slave_reg_reset_out(slave_reg_reset_out));

  ehrc_lane_partner #(.LOCK_DLY(4)) i_partner (
    .clk_in(clk_in), .blk_rst_in(blk_rst_out), .rx_pcs_lock_out(rx_pcs_lock_in));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_in      <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    d = rd_data_out;
  endtask

  // Bounded wait for status and block resets to settle
  task automatic wait_st(input logic [13:0] exp);
    int i;
    i = 0;
    while ({rx_pcs_ready_out, tx_lanes_stable_out, blk_rst_out} !== exp && i < 80) begin
      step(1);
      i++;
    end
    chk("settle", 32'({rx_pcs_ready_out, tx_lanes_stable_out, blk_rst_out}), 32'(exp));
    // Stop at the bound only if still unsettled
    if ({rx_pcs_ready_out, tx_lanes_stable_out, blk_rst_out} !== exp) begin
      tally_and_finish();
    end
  endtask

  initial begin
    n_fail = 0;
    num_checks = 0;
    sys_rst_in = 1'b1;
    reconfig_reset_in = 1'b1;
    hard_rst_in = 5'h1E;
    rate_100g_in = 1'b0;
    d2d_master_in = 1'b1;
    addr_in = 8'h00;
    wr_data_in = 32'h0000_0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    step(19);
    chk("blk_rst_out", 32'(blk_rst_out), 32'h0000_0FFF);
    chk("lanes_pcs", 32'({rx_pcs_ready_out, tx_lanes_stable_out}), 32'h0);
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    step(3);
    // Register and reconfiguration resets released together
    @(posedge clk_in);
    hard_rst_in.lane_register_reset_n <= 1'b1;
    reconfig_reset_in <= 1'b0;
    wr_reg(REG_CTRL_OFS, 32'h0000_0001);
    rd_reg(REG_STAT_OFS, rdv);
    chk("status seq", rdv, 32'h0000_0004);
    rd_reg(REG_CTRL_OFS, rdv);
    chk("ctrl early", rdv, 32'h0000_0000);
    wait_st({2'b11, 12'h000});
    rd_reg(REG_STAT_OFS, rdv);
    chk("status up", rdv, 32'h0000_0003);
    rd_reg(8'h0C, rdv);
    chk("adapt done", rdv, 32'h0B00_0126);
    step(1);
    chk("rd_data idle", rd_data_out, 32'h0000_0000);
    rd_reg(8'hFC, rdv);
    chk("unmapped", rdv, 32'h0000_0000);
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_in);
      rate_100g_in <= r[0];
      // Second pass runs as a slave lane
      d2d_master_in <= !r[0];
      for (int k = 0; k < 10; k++) begin
        hidx = 5;
        ctl = 5'h00;
        st = 2'b00;
        case (k)
          0, 2: begin
            hidx = (k == 0) ? 1 : 5;
            ctl = (k == 0) ? 5'h00 : 5'h02;
            m = TXB | ((r != 0) ? TXF : 12'h000);
            st = 2'b10;
          end
          1, 3: begin
            hidx = (k == 1) ? 2 : 5;
            ctl = (k == 1) ? 5'h00 : 5'h04;
            m = RXB | ((r != 0) ? RXF : 12'h000);
            st = 2'b01;
          end
          4, 7: begin
            hidx = (k == 7) ? 0 : 5;
            ctl = (k == 7) ? 5'h08 : 5'h01;
            m = (r != 0) ? 12'hFFF : SYS_MASK;
          end
          5, 6: begin
            ctl = (k == 5) ? 5'h08 : 5'h10;
            m = 12'h001 << ((k == 5) ? BLK_TX_STA : BLK_RX_STA);
            st = 2'b11;
          end
          default: begin
            hidx = k - 5;
            m = (k == 8) ? TXF : RXF;
          end
        endcase
        if (ctl != 5'h00) begin
          wr_reg(REG_CTRL_OFS, 32'(ctl));
        end
        if (hidx < 5) begin
          @(posedge clk_in);
          hard_rst_in[hidx] <= 1'b0;
        end
        step(3);
        chk("blk map", 32'(blk_rst_out), 32'(m));
        chk("tx fec", 32'(tx_fec_rst_out), m[BLK_TX_FEC] ? 32'hF : 32'h0);
        chk("rx fec", 32'(rx_fec_rst_out), m[BLK_RX_FEC] ? 32'hF : 32'h0);
        step(25);
        chk("blk held", 32'(blk_rst_out), 32'(m));
        if (k < 8) begin
          chk("lanes_pcs", 32'({rx_pcs_ready_out, tx_lanes_stable_out}), 32'(st));
        end
        chk("slave reset", 32'(slave_reg_reset_out), (k == 7 && r == 0) ? 32'h1 : 32'h0);
        if (k == 1) begin
          rd_reg(8'h0C, rdv);
          chk("adapt down", rdv, 32'h0000_0000);
        end
        if (hidx < 5) begin
          @(posedge clk_in);
          hard_rst_in[hidx] <= 1'b1;
        end else begin
          wr_reg(REG_CTRL_OFS, 32'h0000_0000);
        end
        wait_st({2'b11, 12'h000});
      end
    end
    // No PMA setting changes here, so no PMA reset or load
    // Both datapath resets held together, TX released before RX
    @(posedge clk_in);
    hard_rst_in <= 5'h19;
    step(3);
    chk("both paths", 32'(blk_rst_out), 32'(TXB | RXB | TXF | RXF));
    @(posedge clk_in);
    hard_rst_in <= 5'h1B;
    step(12);
    chk("tx first", 32'({rx_pcs_ready_out, tx_lanes_stable_out}), 32'h1);
    @(posedge clk_in);
    hard_rst_in <= 5'h1F;
    wait_st({2'b11, 12'h000});
    // Reconfiguration reset drops only the statistics clears
    wr_reg(REG_CTRL_OFS, 32'h0000_000A);
    @(posedge clk_in);
    reconfig_reset_in <= 1'b1;
    @(posedge clk_in);
    reconfig_reset_in <= 1'b0;
    rd_reg(REG_CTRL_OFS, rdv);
    chk("ctrl reconfig", rdv, 32'h0000_0002);
    wr_reg(REG_CTRL_OFS, 32'hFFFF_FFE0);
    rd_reg(REG_CTRL_OFS, rdv);
    chk("ctrl high bits", rdv, 32'h0000_0000);
    wait_st({2'b11, 12'h000});
    tally_and_finish();
  end
endmodule // ehrc_reset_ctrl_tb
